/* File: include/gpsl_pkg.sv */
package gpsl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int          NPINS       = 8;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 16;
  localparam int          FIELD_LSB   = 0;
  localparam int          FIXED_INPUT = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [7:0]  IDX_DIR     = 8'h4C;
  localparam logic [7:0]  IDX_POL     = 8'h4E;
  localparam logic [7:0]  IDX_LATCH   = 8'h50;
  localparam logic [7:0]  IDX_WAKE    = 8'h52;
  localparam logic [7:0]  IDX_STAT    = 8'h54;
  localparam logic [7:0]  IDX_EVT     = 8'h70;
  localparam logic [7:0]  IDX_EVT_EN  = 8'h72;
  localparam logic [7:0]  IDX_EVT_CLR = 8'h74;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  RST_DIR     = 8'hFF;
  localparam logic [7:0]  RST_POL     = 8'hFF;
  localparam logic [7:0]  RST_LATCH   = 8'h00;
  localparam logic [7:0]  RST_WAKE    = 8'h00;
  localparam logic [7:0]  RST_LEVEL   = 8'hFF;
  localparam logic [7:0]  RST_EVT_EN  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic is_input;
    logic pol;
    logic latch_mode;
    logic level;
  } gpsl_pin_cfg_t;

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_en;
  } gpsl_pad_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } gpsl_bus_st_t;

endpackage

/* File: design/gpsl_pin.sv */
`timescale 1ns/100ps
module gpsl_pin (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Configuration
  input  gpsl_pkg::gpsl_pin_cfg_t cfg,
  input  wire logic              clr,
  // Pad
  input  wire logic              pad_in,
  output gpsl_pkg::gpsl_pad_t    pad,
  // Status
  output logic                   live,
  output logic                   sticky
);

  logic                meta_r;
  logic                live_r;
  logic                sticky_r;
  logic                sticky_nxt;
  gpsl_pkg::gpsl_pad_t pad_r;
  gpsl_pkg::gpsl_pad_t pad_nxt;
  wire                 active;
  wire                 drive;

  ////////////////////////////////////////////////////////////////////////////////
  // Input path
  // Polarity 1 means the low level is the active one
  assign active = cfg.pol ? ~live_r : live_r;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    if (!cfg.latch_mode) begin
      sticky_nxt = 1'b0;
    end else if (cfg.is_input && active) begin
      sticky_nxt = 1'b1;
    end else if (clr) begin
      sticky_nxt = 1'b0;
    end else begin
      sticky_nxt = sticky_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output path
  // Open drain only ever pulls low; the pull-up supplies the high
  assign drive           = ~cfg.is_input & (~cfg.pol | ~cfg.level);
  assign pad_nxt.out     = cfg.pol ? 1'b0 : cfg.level;
  assign pad_nxt.oe_n    = ~drive;
  assign pad_nxt.pull_en = cfg.pol;

  ////////////////////////////////////////////////////////////////////////////////
  // Flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= 1'b0;
      live_r   <= 1'b0;
      sticky_r <= 1'b0;
      pad_r    <= 3'b011;
    end else begin
      meta_r   <= pad_in;
      live_r   <= meta_r;
      sticky_r <= sticky_nxt;
      pad_r    <= pad_nxt;
    end
  end

  assign live   = live_r;
  assign sticky = sticky_r;
  assign pad    = pad_r;

endmodule

/* File: design/gpsl_top.sv */
`timescale 1ns/100ps
module gpsl_top #(
  parameter int NPINS = gpsl_pkg::NPINS
) (
  // Clock and resets
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          por_n,
  // Avalon-MM slave
  input  wire logic [gpsl_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [gpsl_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [gpsl_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  // Pins
  input  wire logic [NPINS-1:0]              pin_in,
  output logic      [NPINS-1:0]              pin_out,
  output logic      [NPINS-1:0]              pin_oe_n,
  output logic      [NPINS-1:0]              pin_pull_en,
  // Interrupts
  output logic                               wake_irq,
  output logic                               irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  gpsl_pkg::gpsl_bus_st_t         st_r;
  gpsl_pkg::gpsl_bus_st_t         st_nxt;
  logic [gpsl_pkg::DATA_W-1:0]    rdata_r;
  logic [gpsl_pkg::DATA_W-1:0]    rdata_nxt;
  logic                           wait_r;
  logic [NPINS-1:0]               pin_direction_bits_r;
  logic [NPINS-1:0]               pin_direction_bits_nxt;
  logic [NPINS-1:0]               pin_polarity_bits_r;
  logic [NPINS-1:0]               pin_polarity_bits_nxt;
  logic [NPINS-1:0]               pin_latch_mode_bits_r;
  logic [NPINS-1:0]               pin_latch_mode_bits_nxt;
  logic [NPINS-1:0]               pin_wake_mask_bits_r;
  logic [NPINS-1:0]               pin_wake_mask_bits_nxt;
  logic [NPINS-1:0]               level_r;
  logic [NPINS-1:0]               level_nxt;
  logic [NPINS-1:0]               evt_r;
  logic [NPINS-1:0]               evt_nxt;
  logic [NPINS-1:0]               evt_en_r;
  logic [NPINS-1:0]               evt_en_nxt;
  logic [NPINS-1:0]               hit_r;
  logic                           wake_irq_r;
  logic                           irq_r;
  logic [NPINS-1:0]               live;
  logic [NPINS-1:0]               sticky;
  logic [NPINS-1:0]               stat_clr;
  logic [NPINS-1:0]               pin_status_bits;
  logic [NPINS-1:0]               hit;
  logic [NPINS-1:0]               evt_clr;
  logic [NPINS-1:0]               wdata;
  logic [NPINS-1:0]               dir_mask;
  logic [gpsl_pkg::REG_W-1:0]     rd_val;
  gpsl_pkg::gpsl_pin_cfg_t        cfg     [NPINS];
  gpsl_pkg::gpsl_pad_t            pad     [NPINS];
  logic                           acc;
  logic                           wr_go;
  logic                           rd_req;
  logic                           sel_dir;
  logic                           sel_pol;
  logic                           sel_latch;
  logic                           sel_wake;
  logic                           sel_stat;
  logic                           sel_evt;
  logic                           sel_evt_en;
  logic                           sel_evt_clr;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign sel_dir     = avs_address == gpsl_pkg::IDX_DIR;
  assign sel_pol     = avs_address == gpsl_pkg::IDX_POL;
  assign sel_latch   = avs_address == gpsl_pkg::IDX_LATCH;
  assign sel_wake    = avs_address == gpsl_pkg::IDX_WAKE;
  assign sel_stat    = avs_address == gpsl_pkg::IDX_STAT;
  assign sel_evt     = avs_address == gpsl_pkg::IDX_EVT;
  assign sel_evt_en  = avs_address == gpsl_pkg::IDX_EVT_EN;
  assign sel_evt_clr = avs_address == gpsl_pkg::IDX_EVT_CLR;

  // Only the low byte holds fields; upper lanes are dropped
  assign acc    = st_r == gpsl_pkg::BUS_ACK;
  assign wr_go  = acc & avs_write & avs_byteenable[0];
  assign rd_req = (st_r == gpsl_pkg::BUS_IDLE) & avs_read;
  assign wdata  = avs_writedata[gpsl_pkg::FIELD_LSB +: NPINS];

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  // One wait cycle, then waitrequest drops for exactly one cycle
  always_comb begin
    st_nxt    = st_r;
    rdata_nxt = rdata_r;
    unique case (st_r)
      gpsl_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_nxt = gpsl_pkg::BUS_ACK;
        end
        if (rd_req) begin
          rdata_nxt = {{(gpsl_pkg::DATA_W-gpsl_pkg::REG_W){1'b0}}, rd_val};
        end
      end
      gpsl_pkg::BUS_ACK: begin
        st_nxt = gpsl_pkg::BUS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Upper byte of every register reads zero; unmapped reads give zero
  assign pin_status_bits = (pin_latch_mode_bits_r & sticky) | (~pin_latch_mode_bits_r & live);

  always_comb begin
    rd_val = '0;
    if (sel_dir) begin
      rd_val[NPINS-1:0] = pin_direction_bits_r;
    end else if (sel_pol) begin
      rd_val[NPINS-1:0] = pin_polarity_bits_r;
    end else if (sel_latch) begin
      rd_val[NPINS-1:0] = pin_latch_mode_bits_r;
    end else if (sel_wake) begin
      rd_val[NPINS-1:0] = pin_wake_mask_bits_r;
    end else if (sel_stat) begin
      rd_val[NPINS-1:0] = pin_status_bits;
    end else if (sel_evt) begin
      rd_val[NPINS-1:0] = evt_r;
    end else if (sel_evt_en) begin
      rd_val[NPINS-1:0] = evt_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  // Fixed-input pin keeps its direction bit at one whatever is written
  assign dir_mask = NPINS'(1) << gpsl_pkg::FIXED_INPUT;

  assign pin_direction_bits_nxt  = (wr_go && sel_dir) ? (wdata | dir_mask) : pin_direction_bits_r;
  assign pin_polarity_bits_nxt   = (wr_go && sel_pol) ? wdata : pin_polarity_bits_r;
  assign pin_latch_mode_bits_nxt = (wr_go && sel_latch) ? wdata : pin_latch_mode_bits_r;
  assign pin_wake_mask_bits_nxt  = (wr_go && sel_wake) ? wdata : pin_wake_mask_bits_r;
  assign level_nxt               = (wr_go && sel_stat) ? wdata : level_r;
  assign evt_en_nxt              = (wr_go && sel_evt_en) ? wdata : evt_en_r;

  // Status write: a zero in a bit position clears that flag
  assign stat_clr = (wr_go && sel_stat) ? ~wdata : '0;
  assign evt_clr  = (wr_go && sel_evt_clr) ? wdata : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin logic
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      assign cfg[g].is_input   = pin_direction_bits_r[g];
      assign cfg[g].pol        = pin_polarity_bits_r[g];
      assign cfg[g].latch_mode = pin_latch_mode_bits_r[g];
      assign cfg[g].level      = level_r[g];

      gpsl_pin u_pin (
        .clk    (clk),
        .rst_n  (rst_n),
        .cfg    (cfg[g]),
        .clr    (stat_clr[g]),
        .pad_in (pin_in[g]),
        .pad    (pad[g]),
        .live   (live[g]),
        .sticky (sticky[g])
      );

      assign pin_out[g]     = pad[g].out;
      assign pin_oe_n[g]    = pad[g].oe_n;
      assign pin_pull_en[g] = pad[g].pull_en;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts
  assign hit = pin_wake_mask_bits_r & sticky;

  // New wake hits set event bits; a set beats a clear in the same cycle
  assign evt_nxt = (evt_r & ~evt_clr) | (hit & ~hit_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on state
  // Kept across ordinary resets, so only por_n restores it
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pin_direction_bits_r <= gpsl_pkg::RST_DIR;
    end else begin
      pin_direction_bits_r <= pin_direction_bits_nxt;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pin_polarity_bits_r <= gpsl_pkg::RST_POL;
    end else begin
      pin_polarity_bits_r <= pin_polarity_bits_nxt;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pin_wake_mask_bits_r <= gpsl_pkg::RST_WAKE;
    end else begin
      pin_wake_mask_bits_r <= pin_wake_mask_bits_nxt;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      level_r <= gpsl_pkg::RST_LEVEL;
    end else begin
      level_r <= level_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ordinary reset state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= gpsl_pkg::BUS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Registered so the master never sees a combinational glitch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= st_nxt != gpsl_pkg::BUS_ACK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_latch_mode_bits_r <= gpsl_pkg::RST_LATCH;
    end else begin
      pin_latch_mode_bits_r <= pin_latch_mode_bits_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= '0;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_en_r <= gpsl_pkg::RST_EVT_EN;
    end else begin
      evt_en_r <= evt_en_nxt;
    end
  end

  // Previous hit level, so a held hit raises only one event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_r <= '0;
    end else begin
      hit_r <= hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_irq_r <= 1'b0;
    end else begin
      wake_irq_r <= |hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_nxt & evt_en_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign wake_irq        = wake_irq_r;
  assign irq             = irq_r;

endmodule

/* File: testbench/gpsl_pad_model.sv */
`timescale 1ns/100ps
module gpsl_pad_model (
  // Clock
  input  wire logic       clk,
  // Design pads
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pull_en,
  // Outside drivers
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  // Undriven pad with no pull toggles, so no stale level is ever seen
  logic [7:0] float_r = 8'h00;

  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end

  // Pad driver wins, then outside driver, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_drv[i] :
                  pin_pull_en[i] ? 1'b1 : float_r[i];
    end
  end
endmodule

/* File: testbench/gpsl_checker.sv */
`timescale 1ns/100ps
module gpsl_checker #(
  parameter int NPINS = 8
) (
  // Clock and resets
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             por_n,
  // Bus
  input wire logic [7:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [3:0]       avs_byteenable,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  // Pins and interrupts
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe_n,
  input wire logic [NPINS-1:0] pin_pull_en,
  input wire logic             wake_irq,
  input wire logic             irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire wr_ack = avs_write && !avs_waitrequest;

  a_wait_taken: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_od_no_high: assert property ((~pin_oe_n & pin_pull_en & pin_out) == {NPINS{1'b0}})
    else $error("open drain drives high");
  a_pin1_input: assert property (pin_oe_n[1])
    else $error("pin 1 driven");
  a_rdata_hold: assert property (!$stable(avs_readdata) |-> $fell(avs_waitrequest) && $past(avs_read))
    else $error("read data moved");
  // Sticky can only drop through a register write
  a_wake_sticky: assert property (
    $fell(wake_irq) |-> $past(wr_ack, 1) || $past(wr_ack, 2) || $past(wr_ack, 3))
    else $error("wake dropped by itself");
endmodule

bind gpsl_top gpsl_checker #(.NPINS(NPINS)) u_gpsl_checker (
  .clk(clk), .rst_n(rst_n), .por_n(por_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pin_pull_en(pin_pull_en), .wake_irq(wake_irq), .irq(irq)
);

/* File: testbench/tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        por_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pull_en;
  logic [7:0]  ext_drv = 8'h00;
  logic [7:0]  ext_en = 8'hFF;
  logic        wake_irq, irq;
  logic [7:0]  rd;
  int          n_errors = 0;
  int          n_tests = 0;

  gpsl_top u_gpsl_top (.clk(clk), .rst_n(rst_n), .por_n(por_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pull_en(pin_pull_en), .wake_irq(wake_irq), .irq(irq));
  gpsl_pad_model u_gpsl_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_en(pin_pull_en), .ext_drv(ext_drv), .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Master waits for the slave, never a fixed count
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !is_wr;
    avs_write <= is_wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata[7:0];
    if (k >= 50) begin
      n_errors++;
      print_verdict();
    end else begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask

  // Ends on a falling edge so outputs are settled when compared
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc("dir", gpsl_pkg::IDX_DIR, 8'hFF);
    rdc("pol", gpsl_pkg::IDX_POL, 8'hFF);
    rdc("latch", gpsl_pkg::IDX_LATCH, 8'h00);
    rdc("wake", gpsl_pkg::IDX_WAKE, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    // Low byte lane off, so the write must not land
    avs_byteenable <= 4'hE;
    wr(gpsl_pkg::IDX_WAKE, 8'hFF);
    avs_byteenable <= 4'hF;
    rdc("lane off", gpsl_pkg::IDX_WAKE, 8'h00);
    settle(1);
    `CHK("oe_n", 8'hFF, pin_oe_n)
    `CHK("pull", 8'hFF, pin_pull_en)
    $display("test reset done");
  endtask

  task automatic t_por;
    wr(gpsl_pkg::IDX_POL, 8'h5A);
    wr(gpsl_pkg::IDX_LATCH, 8'h81);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc("pol kept", gpsl_pkg::IDX_POL, 8'h5A);
    rdc("latch rst", gpsl_pkg::IDX_LATCH, 8'h00);
    @(posedge clk) por_n <= 1'b0;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    rdc("pol por", gpsl_pkg::IDX_POL, 8'hFF);
    $display("test por done");
  endtask

  task automatic t_live;
    ext_drv <= 8'hA5;
    settle(3);
    rdc("live", gpsl_pkg::IDX_STAT, 8'hA5);
    $display("test live done");
  endtask

  // Pin 0 active high, pin 2 active low, both latched, pin 0 wakes
  task automatic t_sticky;
    ext_drv <= 8'h04;
    wr(gpsl_pkg::IDX_POL, 8'hFE);
    wr(gpsl_pkg::IDX_LATCH, 8'h05);
    wr(gpsl_pkg::IDX_WAKE, 8'h01);
    settle(3);
    rdc("quiet", gpsl_pkg::IDX_STAT, 8'h00);
    settle(0);
    `CHK("wake idle", 1'b0, wake_irq)
    @(posedge clk) ext_drv <= 8'h01;
    settle(2);
    @(posedge clk) ext_drv <= 8'h04;
    settle(4);
    rdc("latched", gpsl_pkg::IDX_STAT, 8'h05);
    settle(0);
    `CHK("wake", 1'b1, wake_irq)
    `CHK("irq masked", 1'b0, irq)
    rdc("event", gpsl_pkg::IDX_EVT, 8'h01);
    wr(gpsl_pkg::IDX_EVT_EN, 8'h01);
    settle(2);
    `CHK("irq", 1'b1, irq)
    wr(gpsl_pkg::IDX_EVT_CLR, 8'h01);
    settle(2);
    `CHK("irq clr", 1'b0, irq)
    rdc("event clr", gpsl_pkg::IDX_EVT, 8'h00);
    wr(gpsl_pkg::IDX_STAT, 8'hFE);
    rdc("one clr", gpsl_pkg::IDX_STAT, 8'h04);
    settle(2);
    `CHK("wake clr", 1'b0, wake_irq)
    wr(gpsl_pkg::IDX_LATCH, 8'h01);
    rdc("live2", gpsl_pkg::IDX_STAT, 8'h04);
    wr(gpsl_pkg::IDX_LATCH, 8'h05);
    rdc("live clr", gpsl_pkg::IDX_STAT, 8'h00);
    $display("test sticky done");
  endtask

  // Pins 0, 2, 3 push-pull, pin 1 fixed input, 4-7 open drain, levels 55
  task automatic t_output;
    ext_en <= 8'h02;
    wr(gpsl_pkg::IDX_DIR, 8'h00);
    rdc("dir pin1", gpsl_pkg::IDX_DIR, 8'h02);
    wr(gpsl_pkg::IDX_POL, 8'hF0);
    wr(gpsl_pkg::IDX_STAT, 8'h55);
    settle(2);
    `CHK("oe_n", 8'h52, pin_oe_n)
    `CHK("pull", 8'hF0, pin_pull_en)
    `CHK("out", 8'h05, pin_out & ~pin_oe_n)
    $display("test output done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_por();
    t_live();
    t_sticky();
    t_output();
    print_verdict();
  end
endmodule
